//--- hw/tsense_pkg.sv
// Shared constants and types for the temperature word readout block.
package tsense_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int TEMP_W = 14;
  localparam int WORD_W = 16;
  localparam int TX_BITS = 16;
  localparam int RX_BITS = 8;
  localparam int CNT_W = 5;
  localparam int TIMER_W = 24;
  localparam logic [1:0] LOW_BITS = 2'h3;
  localparam logic [TEMP_W-1:0] TEMP_RESET = 14'h0000;
  localparam logic [WORD_W-1:0] ID_WORD_DEF = 16'h2A53; // Arbitrary neutral identity value.

  // ----------------------------------------------------------------
  // Mode commands and reference codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CONT = 8'h00;
  localparam logic [7:0] CMD_SHDN = 8'hFF;
  localparam logic [TEMP_W-1:0] T_LSB_CODE = 14'h0001;
  localparam logic [WORD_W-1:0] T_LSB_WORD = 16'h0007;
  localparam logic [TEMP_W-1:0] T25_CODE = 14'h0320;
  localparam logic [WORD_W-1:0] T25_WORD = 16'h0C83;
  localparam logic [TEMP_W-1:0] T125_CODE = 14'h0FA0;
  localparam logic [WORD_W-1:0] T125_WORD = 16'h3E83;
  localparam logic [TEMP_W-1:0] T150_CODE = 14'h12C0;
  localparam logic [WORD_W-1:0] T150_WORD = 16'h4B03;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MCLK_HZ = 40_000_000;
  localparam int CONV_TIME_MS = 228;
  localparam int CONV_CYCLES_DEF = CONV_TIME_MS * (MCLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    MODE_CONT = 1'b0,
    MODE_SHDN = 1'b1
  } mode_t;

  typedef struct packed {
    logic sel_n;
    logic data_in;
  } link_in_t;

endpackage

//--- hw/temp_word_out.sv
// Temperature sensor conversion timebase and serial word readout.
// Functional notes
// - Power-up starts in continuous conversion, no command.
// - Word before first conversion is invalid.
// - Supply-rise reset restores default state in the system clock domain; rx_r and rx_cnt_r are not reset.
// - Temperature is 14-bit two's complement, 0.03125 step.
// - Temperature in bits 15:2, low bits ones.
// - One step above zero reads 0007.
// - Plus 150 reads 4B03, plus 125 reads 3E83.
// - Plus 25 reads 0C83.
// - Word shifts out MSB first.
// - Out on falling edge, in on rising edge.
`timescale 1ns/1ps
`default_nettype none
module temp_word_out
  import tsense_pkg::*;
#(
  // conversion period that the host must wait out
  parameter int CONV_CYCLES = CONV_CYCLES_DEF,
  parameter logic [WORD_W-1:0] DEV_ID = ID_WORD_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic shift_clock_in,
  input wire link_in_t link_in,
  input wire logic [TEMP_W-1:0] temp_code_in,
  output logic sio_out,
  output logic sio_oe,
  output logic word_valid,
  output logic shutdown
);

  // ----------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------
  mode_t mode_r, mode_nxt;
  logic [TIMER_W-1:0] timer_r, timer_nxt;
  logic [TEMP_W-1:0] temp_r, temp_nxt;
  logic valid_r, valid_nxt;
  logic [WORD_W-1:0] tx_word_r, tx_word_nxt;
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic seen_r, seen_nxt;
  logic cs_rise;
  logic [CNT_W-1:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic [CNT_W-1:0] rx_cnt_r, rx_cnt_nxt;

  assign cs_rise = cs_s2_r & ~cs_s3_r;

  always_comb begin
    mode_nxt = mode_r;
    timer_nxt = timer_r;
    temp_nxt = temp_r;
    valid_nxt = valid_r;
    tx_word_nxt = tx_word_r;
    seen_nxt = seen_r | ~cs_s2_r;
    // The received byte is stable once the frame clock has stopped.
    if (cs_rise && seen_r && rx_cnt_r >= CNT_W'(RX_BITS)) begin
      case (rx_r)
        CMD_CONT: mode_nxt = MODE_CONT;
        CMD_SHDN: mode_nxt = MODE_SHDN;
        default: mode_nxt = mode_r;
      endcase
    end
    case (mode_r)
      MODE_CONT: begin
        if (timer_r == TIMER_W'(CONV_CYCLES - 1)) begin
          timer_nxt = '0;
          temp_nxt = temp_code_in;
          valid_nxt = 1'b1;
        end else begin
          timer_nxt = timer_r + TIMER_W'(1);
        end
      end
      MODE_SHDN: timer_nxt = '0;
      default: timer_nxt = '0;
    endcase
    if (cs_s2_r) begin
      tx_word_nxt = (mode_r == MODE_SHDN) ? DEV_ID : {temp_r, LOW_BITS};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_r <= MODE_CONT;
      timer_r <= '0;
      temp_r <= TEMP_RESET;
      valid_r <= 1'b0;
      tx_word_r <= {TEMP_RESET, LOW_BITS};
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      seen_r <= 1'b0;
      word_valid <= 1'b0;
      shutdown <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      timer_r <= timer_nxt;
      temp_r <= temp_nxt;
      valid_r <= valid_nxt;
      tx_word_r <= tx_word_nxt;
      cs_s1_r <= link_in.sel_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      seen_r <= seen_nxt;
      word_valid <= valid_nxt;
      shutdown <= (mode_nxt == MODE_SHDN);
    end
  end

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  // The link clock stops between frames, so the frame select itself clears
  // the bit counter; the word is reloaded by the other side meanwhile.
  always_comb begin
    bit_cnt_nxt = (bit_cnt_r == {CNT_W{1'b1}}) ? bit_cnt_r : bit_cnt_r + CNT_W'(1);
    rx_nxt = rx_r;
    rx_cnt_nxt = '0;
    if (bit_cnt_r >= CNT_W'(TX_BITS)) begin
      rx_nxt = {rx_r[6:0], link_in.data_in};
      rx_cnt_nxt = (rx_cnt_r == {CNT_W{1'b1}}) ? rx_cnt_r : rx_cnt_r + CNT_W'(1);
    end
  end

  always_ff @(negedge shift_clock_in or posedge link_in.sel_n) begin
    if (link_in.sel_n) begin
      bit_cnt_r <= '0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // command bits taken on rising edge
  always_ff @(posedge shift_clock_in) begin
    rx_r <= rx_nxt;
    rx_cnt_r <= rx_cnt_nxt;
  end

  assign sio_out = tx_word_r[4'hF - bit_cnt_r[3:0]];
  assign sio_oe = ~link_in.sel_n & (bit_cnt_r < CNT_W'(TX_BITS));

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property fmt_p(logic [TEMP_W-1:0] t, logic [WORD_W-1:0] w);
    @(posedge mclk) disable iff (!rst_n)
      cs_s2_r && mode_r == MODE_CONT && temp_r == t |=> tx_word_r == w;
  endproperty

  sequence conv_end_s;
    mode_r == MODE_CONT && timer_r == TIMER_W'(CONV_CYCLES - 1);
  endsequence

  // Every check in this block but the first and the two link clock checks is off while reset is low,
  // since the supply reset may cut any conversion or frame short; those two are off while deselected.
  reset_default_a: assert property (@(posedge mclk)
    !rst_n |=> mode_r == MODE_CONT && !valid_r && timer_r == '0)
    else $error("Reset state wrong.");
  conv_runs_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_r == MODE_CONT && timer_r != TIMER_W'(CONV_CYCLES - 1)
    |=> timer_r == $past(timer_r) + TIMER_W'(1))
    else $error("Timebase stalled.");
  valid_rise_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(valid_r) |-> $past(timer_r) == TIMER_W'(CONV_CYCLES - 1))
    else $error("Valid before conversion end.");
  conv_latch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    conv_end_s |=> valid_r && temp_r == $past(temp_code_in) ##1 word_valid)
    else $error("Result not latched.");
  low_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_r == MODE_CONT && cs_s2_r
    |=> tx_word_r[1:0] == LOW_BITS && tx_word_r[15:2] == $past(temp_r))
    else $error("Word layout wrong.");
  lsb_code_a: assert property (fmt_p(T_LSB_CODE, T_LSB_WORD))
    else $error("Step code wrong.");
  hot_code_a: assert property (fmt_p(T150_CODE, T150_WORD))
    else $error("150 code wrong.");
  warm_code_a: assert property (fmt_p(T125_CODE, T125_WORD))
    else $error("125 code wrong.");
  room_code_a: assert property (fmt_p(T25_CODE, T25_WORD))
    else $error("25 code wrong.");
  first_bit_a: assert property (@(posedge shift_clock_in) disable iff (link_in.sel_n)
    bit_cnt_r == '0 |-> sio_oe && sio_out == tx_word_r[15])
    else $error("First bit not MSB.");
  rx_sample_a: assert property (@(posedge shift_clock_in) disable iff (link_in.sel_n)
    bit_cnt_r >= CNT_W'(TX_BITS) |=> rx_r[0] == $past(link_in.data_in))
    else $error("Input bit missed.");

  // ----------------------------------------------------------------
  // Mode and frame checks
  // ----------------------------------------------------------------
  // A command only counts once the frame clock has stopped and a whole
  // byte came in; a cut receive phase must leave the mode alone.
  sequence cmd_done_s;
    cs_rise && seen_r && rx_cnt_r >= CNT_W'(RX_BITS);
  endsequence

  sequence cmd_shdn_s;
    cmd_done_s ##0 rx_r == CMD_SHDN;
  endsequence

  sequence cmd_cont_s;
    cmd_done_s ##0 rx_r == CMD_CONT;
  endsequence

  cmd_shdn_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_shdn_s |=> mode_r == MODE_SHDN && shutdown)
    else $error("Shutdown command ignored.");
  cmd_cont_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_cont_s |=> mode_r == MODE_CONT && !shutdown)
    else $error("Conversion command ignored.");
  shdn_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    shutdown == (mode_r == MODE_SHDN))
    else $error("Shutdown flag disagrees with mode.");
  shdn_timer_a: assert property (@(posedge mclk) disable iff (!rst_n)
    mode_r == MODE_SHDN |=> timer_r == '0)
    else $error("Timebase runs in shutdown.");
  valid_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
    valid_r |=> valid_r)
    else $error("Valid dropped without reset.");
  // The link side reads the word with no handshake, so it must stay put.
  word_freeze_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !cs_s2_r |=> $stable(tx_word_r))
    else $error("Word moved during a frame.");
  oe_idle_a: assert property (@(posedge mclk)
    link_in.sel_n |-> !sio_oe)
    else $error("Pin driven while deselected.");

endmodule
`default_nettype wire

//--- verification/link_host.sv
// Host model that frames reads and mode writes on the serial link.
`timescale 1ns/1ps
`default_nettype none
module link_host
  import tsense_pkg::*;
(
  input wire logic mclk,
  input wire logic sio_out,
  input wire logic sio_oe,
  output logic shift_clock_in,
  output wire link_in_t link_in
);
  logic seln = 1'b1;
  logic hd_oe = 1'b0;
  logic hd = 1'b0;
  logic flip = 1'b0;
  initial shift_clock_in = 1'b0;
  // Nobody drives the pin here, so it must not hold the last bit.
  always @(posedge mclk) flip <= ~flip;
  assign link_in = {seln, hd_oe ? hd : (sio_oe ? sio_out : flip)};
  task automatic frame(input int ntx, input bit wr, input logic [7:0] cmd,
                       output logic [15:0] w);
    w = '0;
    seln = 1'b0;
    #100;
    for (int k = 0; k < (wr ? 32 : ntx); k++) begin
      shift_clock_in = 1'b1;
      if (k < ntx)
        w = {w[14:0], link_in.data_in};
      #62.5;
      shift_clock_in = 1'b0;
      hd_oe = wr && k >= 15;
      hd = cmd[7 - ((k + 1) % 8)];
      #62.5;
    end
    hd_oe = 1'b0;
    seln = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

//--- verification/temp_sensor_word_output_bench.sv
// Self-checking bench for the temperature word readout.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_word_output_bench;
  import tsense_pkg::*;
  localparam int CONV = 50;
  localparam logic [13:0] CODES [6] = '{14'h0000, T_LSB_CODE, T25_CODE, T125_CODE,
                                        T150_CODE, 14'h3FFF};
  localparam logic [15:0] WORDS [6] = '{16'h0003, 16'h0007, 16'h0C83, 16'h3E83,
                                        16'h4B03, 16'hFFFF};
  logic mclk;
  logic rst_n;
  logic [TEMP_W-1:0] temp_code = '0;
  logic sclk;
  logic sio_out;
  logic sio_oe;
  logic word_valid;
  logic shutdown;
  link_in_t link;
  logic [15:0] w;
  int n_errors = 0;
  int n_checks = 0;
  temp_word_out #(.CONV_CYCLES(CONV)) dut (.mclk(mclk), .rst_n(rst_n),
    .shift_clock_in(sclk), .link_in(link), .temp_code_in(temp_code), .sio_out(sio_out),
    .sio_oe(sio_oe), .word_valid(word_valid), .shutdown(shutdown));
  link_host host (.mclk(mclk), .sio_out(sio_out), .sio_oe(sio_oe),
    .shift_clock_in(sclk), .link_in(link));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_reset();
    cycles(1);
    rst_n = 1'b0;
    cycles(10);
    rst_n = 1'b1;
    cycles(1);
    check("valid", 16'h0, word_valid);
    check("shutdown", 16'h0, shutdown);
    check("oe idle", 16'h0, sio_oe);
    for (int i = 0; i <= CONV + 3 && word_valid !== 1'b1; i++)
      cycles(1);
    check("valid", 16'h1, word_valid);
    if (word_valid !== 1'b1)
      end_of_test();
    $display("reset test done");
  endtask
  task automatic t_codes();
    for (int i = 0; i < 6; i++) begin
      temp_code = CODES[i];
      cycles(2 * CONV + 4);
      host.frame(16, 1'b0, 8'h00, w);
      check("word", WORDS[i], w);
      check("temp", {{2{CODES[i][13]}}, CODES[i]}, 16'($signed(w) >>> 2));
    end
    temp_code = T150_CODE;
    cycles(2 * CONV + 4);
    host.frame(4, 1'b0, 8'h00, w);
    check("lead bits", 16'h0004, w);
    $display("code test done");
  endtask
  task automatic t_shutdown();
    host.frame(16, 1'b1, 8'hFF, w);
    check("word", 16'h4B03, w);
    cycles(2);
    check("shutdown", 16'h1, shutdown);
    host.frame(16, 1'b1, 8'h00, w);
    check("id", ID_WORD_DEF, w);
    cycles(2);
    check("shutdown", 16'h0, shutdown);
    cycles(2 * CONV + 4);
    host.frame(16, 1'b0, 8'h00, w);
    check("word", 16'h4B03, w);
    $display("shutdown test done");
  endtask
  initial begin
    rst_n = 1'b0;
    t_reset();
    t_codes();
    t_shutdown();
    t_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
